// ===== src/key_scan_voice_assigner.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Octave lines lowest to highest encode as 110,101,100,011,010.
// - Notes C sharp to C encode with the fixed four-bit note table.
// - Scan state 0 grounds every octave line.
// - Scan state 1 drives every note line, low C included, high.
// - With no key closed the scan alternates states 0 and 1 only.
// - State 2 latches the sensed octave code and drives that line low.
// - State 3 latches the code of the low note line, completing the key.
// - After state 3 scanning restarts at state 0 while keys stay closed.
// - Higher notes are encoded first and go to earlier channels.
// - Further notes in the same octave repeat state 3, skipping steps.
// - Four channel slots recirculate, one per master clock cycle.
// - Power-up fills all channels with middle C at once; nothing shifts during clear.
// - Code outputs come from the register slot, which also feeds compare.
// - With no key the register recirculates and no key-on rises.
// - The first key lands in channel 1 and is copied to empty channels.
// - Empty channels carry the most recently pressed key, or middle C before the first.
// - A new key loads exactly one free slot, then recirculation resumes.
// - Only the slot being shifted at load time is written.
// - A held key matching its slot keeps recirculating with key-on up.
// - Loading sets that channel's key-on until release is seen.
module key_scan_voice_assigner #(
    parameter int MASTER_DIV = key_scan_pkg::MASTER_DIV
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Initial clear pin
    input wire logic initial_clear_i,
    // Octave lines
    input wire logic [key_scan_pkg::OCT_LINES-1:0] octave_line_i,
    output logic [key_scan_pkg::OCT_LINES-1:0] octave_line_o,
    output logic [key_scan_pkg::OCT_LINES-1:0] octave_line_oe_o,
    // Note lines, bit 0 is the low C line
    input wire logic [key_scan_pkg::NOTE_LINES-1:0] note_line_i,
    output logic [key_scan_pkg::NOTE_LINES-1:0] note_line_o,
    output logic [key_scan_pkg::NOTE_LINES-1:0] note_line_oe_o,
    // Time-shared key code
    output logic [key_scan_pkg::NOTE_W-1:0] note_code_o,
    output logic [key_scan_pkg::OCT_W-1:0] octave_code_o,
    output logic [key_scan_pkg::CH_W-1:0] channel_o,
    output logic key_on_o,
    output logic [key_scan_pkg::CHANNELS-1:0] key_on_out_o
);
    import key_scan_pkg::*;

    localparam int DIV_W = $clog2(MASTER_DIV);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MASTER_DIV - 1);

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] sync3_ff;
    logic [SYNC_W-1:0] pins_ff;
    logic scan_clear;
    logic [DIV_W-1:0] div_ff;
    logic tick_ff;
    key_event_if ev ();

    key_code_t codes_ff [CHANNELS];
    logic [CHANNELS-1:0] held_ff;
    logic [CHANNELS-1:0] seen_ff;
    logic [CH_W-1:0] ptr_ff;
    logic pending_ff;
    key_code_t pending_code_ff;
    key_code_t last_ff;
    logic last_valid_ff;

    logic [CHANNELS-1:0] match_held;
    logic [CH_W-1:0] free_low;
    logic load_gate;
    logic [CHANNELS-1:0] load_mask;
    key_code_t nxt_slot_code;
    logic nxt_slot_held;

    // Three-stage pin synchroniser; a level counts once the second and
    // third stages agree, so a single glitchy sample cannot flip it.
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync1_ff <= SYNC_IDLE;
            sync2_ff <= SYNC_IDLE;
            sync3_ff <= SYNC_IDLE;
            pins_ff <= SYNC_IDLE;
        end else begin
            sync1_ff <= {initial_clear_i, note_line_i, octave_line_i};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pins_ff <= (sync3_ff & ~(sync2_ff ^ sync3_ff)) |
                       (pins_ff & (sync2_ff ^ sync3_ff));
        end
    end

    assign scan_clear = reset_i | pins_ff[SYNC_W-1];

    // Master clock enable; one tick is one channel slot.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == DIV_LAST);
            if (div_ff == DIV_LAST) begin
                div_ff <= '0;
            end else begin
                div_ff <= div_ff + 1'b1;
            end
        end
    end

    key_coder u_coder (
        .sys_clk_i(sys_clk_i),
        .scan_clear_i(scan_clear),
        .tick_i(tick_ff),
        .octave_sense_i(pins_ff[OCT_LINES-1:0]),
        .note_sense_i(pins_ff[OCT_LINES+NOTE_LINES-1:OCT_LINES]),
        .octave_drive_o(octave_line_o),
        .octave_drive_oe_o(octave_line_oe_o),
        .note_drive_o(note_line_o),
        .note_drive_oe_o(note_line_oe_o),
        .ev(ev.coder)
    );

    // Compare the incoming key against every held slot and find the
    // lowest free channel, so the first key goes to channel 1.
    always_comb begin
        match_held = '0;
        free_low = CH_W'(CHANNELS - 1);
        for (int c = CHANNELS - 1; c >= 0; c--) begin
            if (held_ff[c] && codes_ff[c] == ev.code) begin
                match_held[c] = 1'b1;
            end
            if (!held_ff[c]) begin
                free_low = CH_W'(c);
            end
        end
    end

    // The slot at the pointer is the register output this cycle.
    always_comb begin
        load_gate = tick_ff && pending_ff && !held_ff[ptr_ff] &&
                    (ptr_ff == free_low);
        load_mask = '0;
        nxt_slot_code = codes_ff[ptr_ff];
        nxt_slot_held = held_ff[ptr_ff];
        if (load_gate) begin
            load_mask[ptr_ff] = 1'b1;
            nxt_slot_code = pending_code_ff;
            nxt_slot_held = 1'b1;
        end else if (!held_ff[ptr_ff] && last_valid_ff) begin
            nxt_slot_code = last_ff;
        end
    end

    // Recirculating code store.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear) begin
            for (int c = 0; c < CHANNELS; c++) begin
                codes_ff[c] <= POWERUP_CODE;
            end
            ptr_ff <= '0;
        end else if (tick_ff) begin
            codes_ff[ptr_ff] <= nxt_slot_code;
            ptr_ff <= ptr_ff + 1'b1;
        end
    end

    // Key-on state per channel; a load in the same cycle wins.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear) begin
            held_ff <= '0;
            seen_ff <= '0;
        end else begin
            if (ev.round_end) begin
                held_ff <= (held_ff & seen_ff) | load_mask;
                seen_ff <= load_mask;
            end else begin
                held_ff <= held_ff | load_mask;
                seen_ff <= seen_ff | load_mask |
                           (ev.valid ? match_held : '0);
            end
        end
    end

    // New key waiting for its slot, and the most recent key for fill.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear) begin
            pending_ff <= 1'b0;
            pending_code_ff <= POWERUP_CODE;
            last_ff <= POWERUP_CODE;
            last_valid_ff <= 1'b0;
        end else begin
            if (load_gate) begin
                pending_ff <= 1'b0;
                last_ff <= pending_code_ff;
                last_valid_ff <= 1'b1;
            end else if (ev.valid && match_held == '0 && !pending_ff) begin
                pending_ff <= 1'b1;
                pending_code_ff <= ev.code;
            end
        end
    end

    // Output pins present the slot being shifted this cycle.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear) begin
            note_code_o <= POWERUP_CODE[NOTE_W-1:0];
            octave_code_o <= POWERUP_CODE[CODE_W-1:NOTE_W];
            channel_o <= '0;
            key_on_o <= 1'b0;
        end else if (tick_ff) begin
            note_code_o <= nxt_slot_code[NOTE_W-1:0];
            octave_code_o <= nxt_slot_code[CODE_W-1:NOTE_W];
            channel_o <= ptr_ff;
            key_on_o <= nxt_slot_held;
        end
    end

    assign key_on_out_o = held_ff;

endmodule
`default_nettype wire

// ===== src/key_scan_pkg.sv
package key_scan_pkg;

    // Pin and code geometry.
    localparam int OCT_LINES = 5;
    localparam int NOTE_LINES = 13;
    localparam int CHANNELS = 4;
    localparam int OCT_W = 3;
    localparam int NOTE_W = 4;
    localparam int CODE_W = OCT_W + NOTE_W;
    localparam int CH_W = $clog2(CHANNELS);
    localparam int SYNC_W = OCT_LINES + NOTE_LINES + 1;

    // Master clock rate and the derived slot length in system cycles.
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int MASTER_CLK_HZ = 94_000;
    localparam int MASTER_DIV = SYS_CLK_HZ / MASTER_CLK_HZ;

    typedef logic [OCT_W-1:0] oct_code_t;
    typedef logic [NOTE_W-1:0] note_code_t;
    typedef logic [CODE_W-1:0] key_code_t;

    // Index 0 is the lowest octave line.
    localparam oct_code_t OCT_CODE [OCT_LINES] = '{
        3'h6, 3'h5, 3'h4, 3'h3, 3'h2
    };

    // Index 0 is the low C line, then C sharp upward to the top C.
    localparam note_code_t NOTE_CODE [NOTE_LINES] = '{
        4'h1, 4'hf, 4'he, 4'hd, 4'hb, 4'ha, 4'h9,
        4'h7, 4'h6, 4'h5, 4'h3, 4'h2, 4'h1
    };

    // Middle C: third octave line, top C note.
    localparam key_code_t POWERUP_CODE = 7'h41;

    // Idle levels of the synchronised pins: octave lines grounded,
    // note lines high, clear inactive.
    localparam logic [SYNC_W-1:0] SYNC_IDLE =
        {1'b0, {NOTE_LINES{1'b1}}, {OCT_LINES{1'b0}}};

    typedef enum logic [3:0] {
        SCAN_PREP  = 4'h1,
        SCAN_SENSE = 4'h2,
        SCAN_OCT   = 4'h4,
        SCAN_NOTE  = 4'h8
    } scan_state_t;

endpackage

// ===== src/key_event_if.sv
`timescale 1ns/100ps
`default_nettype none
interface key_event_if;
    import key_scan_pkg::*;
    logic valid;
    key_code_t code;
    logic round_end;

    modport coder (output valid, output code, output round_end);
    modport assigner (input valid, input code, input round_end);
endinterface
`default_nettype wire

// ===== src/key_coder.sv
`timescale 1ns/100ps
`default_nettype none
module key_coder (
    // Clock, clear and master rate enable
    input wire logic sys_clk_i,
    input wire logic scan_clear_i,
    input wire logic tick_i,
    // Synchronised line levels
    input wire logic [key_scan_pkg::OCT_LINES-1:0] octave_sense_i,
    input wire logic [key_scan_pkg::NOTE_LINES-1:0] note_sense_i,
    // Line drivers
    output logic [key_scan_pkg::OCT_LINES-1:0] octave_drive_o,
    output logic [key_scan_pkg::OCT_LINES-1:0] octave_drive_oe_o,
    output logic [key_scan_pkg::NOTE_LINES-1:0] note_drive_o,
    output logic [key_scan_pkg::NOTE_LINES-1:0] note_drive_oe_o,
    // Encoded keys
    key_event_if.coder ev
);
    import key_scan_pkg::*;

    scan_state_t state_ff;
    logic [2:0] oct_sel_ff;
    logic [2:0] oct_lim_ff;
    logic [3:0] note_lim_ff;
    oct_code_t oct_code_ff;
    logic oct_hit;
    logic [2:0] oct_idx;
    logic note_hit;
    logic note_more;
    logic [3:0] note_idx;

    // Highest closed octave below the limit, highest closed note below
    // its limit, and whether a lower note in the same octave remains.
    always_comb begin
        oct_hit = 1'b0;
        oct_idx = 3'h0;
        note_hit = 1'b0;
        note_idx = 4'h0;
        note_more = 1'b0;
        for (int i = 0; i < OCT_LINES; i++) begin
            if (octave_sense_i[i] && (3'(i) < oct_lim_ff)) begin
                oct_hit = 1'b1;
                oct_idx = 3'(i);
            end
        end
        for (int j = 0; j < NOTE_LINES; j++) begin
            if (!note_sense_i[j] && (4'(j) < note_lim_ff)) begin
                note_hit = 1'b1;
                note_idx = 4'(j);
            end
        end
        for (int j = 0; j < NOTE_LINES; j++) begin
            if (!note_sense_i[j] && (4'(j) < note_idx)) begin
                note_more = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (scan_clear_i) begin
            state_ff <= SCAN_PREP;
            oct_sel_ff <= 3'h0;
            oct_lim_ff <= 3'(OCT_LINES);
            note_lim_ff <= 4'(NOTE_LINES);
            oct_code_ff <= OCT_CODE[0];
        end else if (tick_i) begin
            case (state_ff)
                SCAN_PREP: begin
                    state_ff <= SCAN_SENSE;
                end
                SCAN_SENSE: begin
                    if (oct_hit) begin
                        oct_sel_ff <= oct_idx;
                        state_ff <= SCAN_OCT;
                    end else begin
                        // Nothing left below the limit: round over.
                        oct_lim_ff <= 3'(OCT_LINES);
                        state_ff <= SCAN_PREP;
                    end
                end
                SCAN_OCT: begin
                    oct_code_ff <= OCT_CODE[oct_sel_ff];
                    note_lim_ff <= 4'(NOTE_LINES);
                    state_ff <= SCAN_NOTE;
                end
                SCAN_NOTE: begin
                    note_lim_ff <= note_idx;
                    if (!(note_hit && note_more)) begin
                        // No lower note left in this octave: restart below this octave.
                        oct_lim_ff <= oct_sel_ff;
                        state_ff <= SCAN_PREP;
                    end
                end
                default: begin
                    state_ff <= SCAN_PREP;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (scan_clear_i) begin
            ev.valid <= 1'b0;
            ev.round_end <= 1'b0;
            ev.code <= POWERUP_CODE;
        end else begin
            ev.valid <= 1'b0;
            ev.round_end <= 1'b0;
            if (tick_i && state_ff == SCAN_SENSE && !oct_hit) begin
                ev.round_end <= 1'b1;
            end
            if (tick_i && state_ff == SCAN_NOTE && note_hit) begin
                ev.valid <= 1'b1;
                // The fixed note table gives the four note bits.
                ev.code <= {oct_code_ff, NOTE_CODE[note_idx]};
            end
        end
    end

    // Drivers follow the state one cycle later; lines are sampled only
    // at the next tick, long after the synchroniser has settled.
    always_ff @(posedge sys_clk_i) begin
        if (scan_clear_i) begin
            octave_drive_o <= '0;
            octave_drive_oe_o <= '1;
            note_drive_o <= '0;
            note_drive_oe_o <= '0;
        end else begin
            octave_drive_o <= '0;
            note_drive_o <= '1;
            octave_drive_oe_o <= '0;
            note_drive_oe_o <= '0;
            case (state_ff)
                SCAN_PREP: octave_drive_oe_o <= '1;
                SCAN_SENSE: note_drive_oe_o <= '1;
                SCAN_OCT,
                SCAN_NOTE: begin
                    octave_drive_oe_o <= OCT_LINES'(1) << oct_sel_ff;
                end
                default: octave_drive_oe_o <= '1;
            endcase
        end
    end

endmodule
`default_nettype wire

// ===== bench/key_matrix_model.sv
`timescale 1ns/100ps
`default_nettype none
// A closed key joins one octave line to one note line. Released octave
// lines sink to 0 and released note lines float to 1, never to old values.
// Voice-count straps are absent, so four voices are fixed.
module key_matrix_model
    import key_scan_pkg::*;
(
    // Closed keys, index octave times NOTE_LINES plus note
    input wire logic [OCT_LINES*NOTE_LINES-1:0] closed_i,
    // Device drivers
    input wire logic [OCT_LINES-1:0] oct_drv_i,
    input wire logic [OCT_LINES-1:0] oct_oe_i,
    input wire logic [NOTE_LINES-1:0] note_drv_i,
    input wire logic [NOTE_LINES-1:0] note_oe_i,
    // Resolved line levels
    output logic [OCT_LINES-1:0] oct_lvl_o,
    output logic [NOTE_LINES-1:0] note_lvl_o
);
    always_comb begin
        oct_lvl_o = oct_oe_i & oct_drv_i;
        note_lvl_o = ~note_oe_i | note_drv_i;
        for (int o = 0; o < OCT_LINES; o++) begin
            for (int n = 0; n < NOTE_LINES; n++) begin
                if (closed_i[o*NOTE_LINES+n] && !oct_oe_i[o]) begin
                    oct_lvl_o[o] |= note_oe_i[n] & note_drv_i[n];
                end
                if (closed_i[o*NOTE_LINES+n] && !note_oe_i[n]) begin
                    note_lvl_o[n] &= ~oct_oe_i[o] | oct_drv_i[o];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/key_scan_voice_assigner_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module key_scan_voice_assigner_asserts
    import key_scan_pkg::*;
#(
    parameter int MASTER_DIV = key_scan_pkg::MASTER_DIV
) (
    // Clock, reset and clear
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic initial_clear_i,
    // Lines
    input wire logic [OCT_LINES-1:0] octave_line_i,
    input wire logic [OCT_LINES-1:0] octave_line_o,
    input wire logic [OCT_LINES-1:0] octave_line_oe_o,
    input wire logic [NOTE_LINES-1:0] note_line_i,
    input wire logic [NOTE_LINES-1:0] note_line_o,
    input wire logic [NOTE_LINES-1:0] note_line_oe_o,
    // Slot outputs
    input wire logic [NOTE_W-1:0] note_code_o,
    input wire logic [OCT_W-1:0] octave_code_o,
    input wire logic [CH_W-1:0] channel_o,
    input wire logic key_on_o,
    input wire logic [CHANNELS-1:0] key_on_out_o
);
    logic [3:0] clr_cnt_ff;
    logic [CH_W-1:0] ch_prev_ff;
    logic [CHANNELS-1:0] kon_prev_ff;
    int gap_ff;
    logic gap_ok_ff;
    logic quiet;
    logic chg;
    logic [CHANNELS-1:0] rise;

    // The clear pin is synchronised inside, so its effect outlasts the pin.
    assign quiet = reset_i || initial_clear_i || clr_cnt_ff != 4'h0;
    assign chg = channel_o != ch_prev_ff;
    assign rise = key_on_out_o & ~kon_prev_ff;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            clr_cnt_ff <= 4'h0;
        end else if (initial_clear_i) begin
            clr_cnt_ff <= 4'hf;
        end else if (clr_cnt_ff != 4'h0) begin
            clr_cnt_ff <= clr_cnt_ff - 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        ch_prev_ff <= channel_o;
        kon_prev_ff <= key_on_out_o;
    end

    always_ff @(posedge sys_clk_i) begin
        if (quiet) begin
            gap_ff <= 0;
            gap_ok_ff <= 1'b0;
        end else if (chg) begin
            gap_ff <= 1;
            gap_ok_ff <= 1'b1;
        end else begin
            gap_ff <= gap_ff + 1;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (quiet);

    sequence sense_quiet;
        (note_line_oe_o == '1 && octave_line_i == '0) [*8];
    endsequence

    AST_OCT_LOW: assert property (
        octave_line_oe_o != '0 |-> octave_line_o == '0)
        else $error("octave line driven high");
    AST_NOTE_HIGH: assert property (
        note_line_oe_o != '0 |-> note_line_o == '1)
        else $error("note line driven low");
    AST_PREP: assert property (
        octave_line_oe_o == '1 |-> note_line_oe_o == '0)
        else $error("note lines driven while preparing");
    AST_SENSE: assert property (
        note_line_oe_o == '1 |-> octave_line_oe_o == '0)
        else $error("octave lines driven while sensing");
    AST_IDLE: assert property (
        sense_quiet ##1 note_line_oe_o != '1 |-> octave_line_oe_o == '1)
        else $error("scan left idle loop without a key");
    AST_ONE_LINE: assert property (
        octave_line_oe_o != '0 && octave_line_oe_o != '1
        |-> $onehot(octave_line_oe_o)) else $error("several lines encoded");
    AST_SLOT_STEP: assert property (
        $changed(channel_o) |-> channel_o == $past(channel_o) + 1'b1)
        else $error("slot order broken");
    AST_SLOT_PERIOD: assert property (
        chg && gap_ok_ff |-> gap_ff == MASTER_DIV)
        else $error("slot length wrong");
    AST_CODE_SLOT: assert property (
        $changed({octave_code_o, note_code_o}) |-> $changed(channel_o))
        else $error("code changed inside a slot");
    AST_KEYON_RISE: assert property (
        rise != '0 |-> key_on_o && rise == (CHANNELS'(1) << channel_o))
        else $error("key-on rose outside its slot");
    AST_KEYON_SLOT: assert property (
        $rose(key_on_o) |-> $changed(channel_o))
        else $error("slot key-on rose mid-slot");
endmodule

bind key_scan_voice_assigner key_scan_voice_assigner_asserts #(
    .MASTER_DIV(MASTER_DIV)
) u_key_scan_voice_assigner_asserts (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .initial_clear_i(initial_clear_i), .octave_line_i(octave_line_i),
    .octave_line_o(octave_line_o), .octave_line_oe_o(octave_line_oe_o),
    .note_line_i(note_line_i), .note_line_o(note_line_o),
    .note_line_oe_o(note_line_oe_o), .note_code_o(note_code_o),
    .octave_code_o(octave_code_o), .channel_o(channel_o),
    .key_on_o(key_on_o), .key_on_out_o(key_on_out_o)
);
`default_nettype wire

// ===== bench/key_scan_voice_assigner_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module key_scan_voice_assigner_tb_top;
    import key_scan_pkg::*;
    localparam int DIV = 8;
    localparam logic [2:0] OCT_EXP [5] = '{3'h6, 3'h5, 3'h4, 3'h3, 3'h2};
    localparam logic [3:0] NOTE_EXP [13] = '{4'h1, 4'hf, 4'he, 4'hd,
        4'hb, 4'ha, 4'h9, 4'h7, 4'h6, 4'h5, 4'h3, 4'h2, 4'h1};
    logic clk;
    logic rst;
    logic clr;
    logic [OCT_LINES*NOTE_LINES-1:0] closed;
    logic [OCT_LINES-1:0] oct_in;
    logic [OCT_LINES-1:0] oct_out;
    logic [OCT_LINES-1:0] oct_oe;
    logic [NOTE_LINES-1:0] note_in;
    logic [NOTE_LINES-1:0] note_out;
    logic [NOTE_LINES-1:0] note_oe;
    logic [NOTE_W-1:0] note_code;
    logic [OCT_W-1:0] oct_code;
    logic [CH_W-1:0] chan;
    logic kon;
    logic [CHANNELS-1:0] kon_out;
    int errors;
    int samples_checked;
    int cycles;

    key_scan_voice_assigner #(.MASTER_DIV(DIV)) u_key_scan_voice_assigner (
        .sys_clk_i(clk), .reset_i(rst), .initial_clear_i(clr),
        .octave_line_i(oct_in), .octave_line_o(oct_out),
        .octave_line_oe_o(oct_oe), .note_line_i(note_in),
        .note_line_o(note_out), .note_line_oe_o(note_oe),
        .note_code_o(note_code), .octave_code_o(oct_code),
        .channel_o(chan), .key_on_o(kon), .key_on_out_o(kon_out));
    key_matrix_model u_key_matrix_model (
        .closed_i(closed), .oct_drv_i(oct_out), .oct_oe_i(oct_oe),
        .note_drv_i(note_out), .note_oe_i(note_oe),
        .oct_lvl_o(oct_in), .note_lvl_o(note_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The whole run needs about 3000 cycles; the ceiling leaves slack.
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 20000) begin
            errors++;
            $display("[ERR] %0t run timed out", $time);
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    function automatic logic [6:0] kc(input int o, input int n);
        return {OCT_EXP[o], NOTE_EXP[n]};
    endfunction

    task automatic press(input int o, input int n, input logic v);
        closed[o*NOTE_LINES+n] = v;
    endtask

    // Waits for a fresh arrival of the given slot.
    task automatic arrive(input int ch);
        logic [CH_W-1:0] last;
        for (int n = 0; n < 64; n++) begin
            last = chan;
            step();
            if (chan !== last && chan === ch[CH_W-1:0]) return;
        end
        chk(0, 1, "slot never arrived");
    endtask

    task automatic wait_kon(input logic [3:0] exp);
        for (int n = 0; n < 400 && kon_out !== exp; n++) step();
        chk(kon_out, exp, "key-on lines");
    endtask

    // Codes packed slot 3 down to slot 0; one full turn lets fills land.
    task automatic slots(input logic [27:0] e, input logic [3:0] ke);
        arrive(0);
        arrive(0);
        for (int c = 0; c < 4; c++) begin
            if (c > 0) arrive(c);
            chk({oct_code, note_code}, e[c*7 +: 7], "slot code");
            chk(kon, ke[c], "slot key-on");
        end
    endtask

    task automatic t_single();
        press(3, 4, 1'b1);
        wait_kon(4'h1);
        slots({4{kc(3, 4)}}, 4'h1);
        press(3, 4, 1'b0);
        wait_kon(4'h0);
        slots({4{kc(3, 4)}}, 4'h0);
        $display("single key done");
    endtask

    task automatic t_two();
        press(1, 2, 1'b1);
        wait_kon(4'h1);
        press(2, 9, 1'b1);
        wait_kon(4'h3);
        slots({{3{kc(2, 9)}}, kc(1, 2)}, 4'h3);
        press(1, 2, 1'b0);
        wait_kon(4'h2);
        press(2, 9, 1'b0);
        wait_kon(4'h0);
        $display("two keys done");
    endtask

    task automatic t_clear();
        press(0, 0, 1'b1);
        wait_kon(4'h1);
        clr = 1'b1;
        repeat (10) step();
        press(0, 0, 1'b0);
        chk(kon_out, 4'h0, "clear key-on");
        chk({oct_code, note_code}, 7'h41, "clear code");
        chk(chan, 0, "clear slot");
        chk(oct_oe, 5'h1f, "clear scan");
        clr = 1'b0;
        slots({4{7'h41}}, 4'h0);
        $display("clear done");
    endtask

    task automatic t_prio();
        press(2, 3, 1'b1);
        press(2, 10, 1'b1);
        wait_kon(4'h3);
        slots({{3{kc(2, 3)}}, kc(2, 10)}, 4'h3);
        press(2, 3, 1'b0);
        press(2, 10, 1'b0);
        wait_kon(4'h0);
        $display("priority done");
    endtask

    task automatic t_codes();
        int o;
        int n;
        for (int i = 0; i < 18; i++) begin
            o = i < 5 ? i : 2;
            n = i < 5 ? 12 : i - 5;
            press(o, n, 1'b1);
            wait_kon(4'h1);
            arrive(0);
            chk({oct_code, note_code}, kc(o, n), "code");
            press(o, n, 1'b0);
            wait_kon(4'h0);
        end
        $display("code table done");
    endtask

    initial begin
        rst = 1'b1;
        clr = 1'b0;
        closed = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (6) step();
        slots({4{7'h41}}, 4'h0);
        $display("power-up done");
        t_single();
        t_two();
        t_clear();
        t_prio();
        t_codes();
        conclude();
    end
endmodule
`default_nettype wire
